// >>> src/ilus_consts.svh
// Constants for the integer logic, upper-immediate and swap slice
// Assumes 32-bit instruction words and a 32-bit classic Wishbone slave
`ifndef ILUS_CONSTS_SVH
`define ILUS_CONSTS_SVH
// ----------------------------------------
// Instruction encodings
// ----------------------------------------
`define ILUS_OP_FMT2      2'h0
`define ILUS_OP_ARITH     2'h2
`define ILUS_OP_MEM       2'h3
`define ILUS_OP2_UPPER    3'h4
`define ILUS_OP3_SWAP     6'h0F
`define ILUS_OP3_SWAP_ALT 6'h1F
`define ILUS_CC_BIT       4
`define ILUS_IMM_BIT      13
`define ILUS_UPPER_LOW    10
// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define ILUS_ADR_CFG      4'h0
`define ILUS_ADR_STATUS   4'h4
`define ILUS_ADR_COUNT    4'h8
`define ILUS_CFG_RST      16'h0201
`endif

// >>> src/ilus_exec.sv
// Integer execution slice: logical ops, upper-immediate load and word swap
// Assumes pipeline and memory port on clk_sys; Wishbone slave for config
//
// Summary of operation
// - Minor opcode 001111 is swap, 011111 is alternate-space swap.
// - Swap exchanges register and memory word atomically, interrupts held off.
// - Swap address is src A plus src B, or plus sign-extended immediate.
// - Alternate swap with immediate bit traps illegal; in user mode privileged.
// - Alternate swap uses instruction space id; plain swap user or supervisor.
// - Misaligned swap address traps without any memory access.
// - Write-half fault may trap after destination took loaded value.
// - Format-two opcode 100 loads upper 22 bits, clears low 10.
// - Upper-immediate load leaves condition flags alone.
// - Upper-immediate with zero destination and zero field is no-operation.
// - No-operation changes nothing but the program counters.
// - Twelve logical opcodes decoded; bit 4 selects flag-setting form.
// - Logical result is src A with src B or sign-extended immediate.
// - Only flag-setting logical forms update condition flags.
// - And-not and or-not invert the second operand first.
// - Exclusive-nor yields complement of exclusive-or.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`include "ilus_consts.svh"
module ilus_exec (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              iss_valid,
   output logic                   iss_ready,
   input  wire logic [31:0]       iss_instr,
   input  wire logic [31:0]       iss_src_a,
   input  wire logic [31:0]       iss_src_b,
   input  wire logic [31:0]       iss_rd_val,
   input  wire logic              processor_state_word_s,
   output ilus_pkg::ilus_res_s    res,
   output logic                   atomic_busy,
   output ilus_pkg::ilus_mem_s    mem,
   input  wire logic              mem_ack,
   input  wire logic              mem_err,
   input  wire logic [31:0]       mem_rdata,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [3:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o
);
   import ilus_pkg::*;

   typedef struct packed {
      ilus_st_e    st;
      logic [31:0] addr;
      logic [7:0]  asi;
      logic [31:0] wdata;
      logic [4:0]  rd;
      logic [31:0] ld;
      ilus_res_s   res;
      logic        wb_ack;
      logic [31:0] wb_dat;
      logic [15:0] cfg;
      ilus_trap_e  last_trap;
      logic [15:0] swap_cnt;
   } ilus_state_s;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_ok_n;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_ok_n = rst_sync_q[1];

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] ilus_sext13(input logic [12:0] v);
      return {{19{v[12]}}, v};
   endfunction

   // Low three opcode bits pick the operation; bit 2 negates the operand
   function automatic logic [31:0] ilus_logic(input logic [2:0] f,
                                              input logic [31:0] a,
                                              input logic [31:0] b);
      logic [31:0] bb;
      bb = f[2] ? ~b : b;
      case (f[1:0])
         2'b01:   return a & bb;
         2'b10:   return a | bb;
         2'b11:   return f[2] ? ~(a ^ b) : (a ^ b);
         default: return 32'h0000_0000;
      endcase
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic [1:0]  f_op;
   logic [5:0]  minor_opcode_field;
   logic [2:0]  format2_opcode_field;
   logic [4:0]  f_rd;
   logic        f_imm;
   logic [31:0] opnd_b;
   logic [31:0] eff_addr;
   logic        iss_fire;
   logic        is_upper;
   logic        is_nop;
   logic        is_logic;
   logic        is_swap;
   logic        is_swap_alt;
   ilus_state_s q;
   ilus_state_s d;

   assign f_op                 = iss_instr[31:30];
   assign f_rd                 = iss_instr[29:25];
   assign minor_opcode_field   = iss_instr[24:19];
   assign format2_opcode_field = iss_instr[24:22];
   assign f_imm                = iss_instr[`ILUS_IMM_BIT];
   assign opnd_b   = f_imm ? ilus_sext13(iss_instr[12:0]) : iss_src_b;
   assign eff_addr = iss_src_a + opnd_b;
   assign iss_fire = iss_valid && iss_ready;
   assign is_upper = f_op == `ILUS_OP_FMT2
                     && format2_opcode_field == `ILUS_OP2_UPPER;
   assign is_nop   = is_upper && f_rd == 5'd0 && iss_instr[21:0] == 22'd0;
   assign is_logic = f_op == `ILUS_OP_ARITH && minor_opcode_field[5] == 1'b0
                     && minor_opcode_field[3] == 1'b0
                     && minor_opcode_field[1:0] != 2'b00;
   assign is_swap     = f_op == `ILUS_OP_MEM
                        && minor_opcode_field == `ILUS_OP3_SWAP;
   assign is_swap_alt = f_op == `ILUS_OP_MEM
                        && minor_opcode_field == `ILUS_OP3_SWAP_ALT;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [31:0] lres;
      lres        = ilus_logic(minor_opcode_field[2:0], iss_src_a, opnd_b);
      d           = q;
      d.res       = '0;
      d.res.rd    = q.rd;
      d.wb_ack    = 1'b0;
      case (q.st)
         ILUS_IDLE: begin
            if (iss_valid) begin
               d.res.valid  = 1'b1;
               d.res.rd     = f_rd;
               d.res.pc_adv = 1'b1;
               if (is_upper) begin
                  d.res.wr_en = !is_nop;
                  d.res.data  = {iss_instr[21:0], {`ILUS_UPPER_LOW{1'b0}}};
               end else if (is_logic) begin
                  d.res.wr_en  = 1'b1;
                  d.res.data   = lres;
                  d.res.icc_wr = minor_opcode_field[`ILUS_CC_BIT];
                  d.res.icc    = {lres[31], lres == 32'd0, 2'b00};
               end else if (is_swap || is_swap_alt) begin
                  // Traps decided before any access is issued
                  if (is_swap_alt && f_imm) begin
                     d.res.trap = ILUS_TRAP_ILLEG;
                  end else if (is_swap_alt && !processor_state_word_s) begin
                     d.res.trap = ILUS_TRAP_PRIV;
                  end else if (eff_addr[1:0] != 2'b00) begin
                     d.res.trap = ILUS_TRAP_ALIGN;
                  end else begin
                     d.res.valid  = 1'b0;
                     d.res.pc_adv = 1'b0;
                     d.st    = ILUS_RD;
                     d.addr  = eff_addr;
                     d.wdata = iss_rd_val;
                     d.rd    = f_rd;
                     d.asi   = is_swap_alt ? iss_instr[12:5]
                               : (processor_state_word_s ? q.cfg[15:8] : q.cfg[7:0]);
                  end
               end else begin
                  d.res.trap = ILUS_TRAP_ILLEG;
               end
               if (d.res.trap != ILUS_TRAP_NONE) begin
                  d.res.trap_valid = 1'b1;
                  d.res.pc_adv     = 1'b0;
                  d.last_trap      = d.res.trap;
               end
            end
         end
         ILUS_RD: begin
            if (mem_ack) begin
               if (mem_err) begin
                  d.st             = ILUS_IDLE;
                  d.res.valid      = 1'b1;
                  d.res.trap_valid = 1'b1;
                  d.res.trap       = ILUS_TRAP_ACCESS;
                  d.last_trap      = ILUS_TRAP_ACCESS;
               end else begin
                  d.ld = mem_rdata;
                  d.st = ILUS_WR;
               end
            end
         end
         ILUS_WR: begin
            if (mem_ack) begin
               d.st         = ILUS_IDLE;
               d.res.valid  = 1'b1;
               d.res.wr_en  = 1'b1;
               d.res.data   = q.ld;
               d.res.pc_adv = !mem_err;
               d.swap_cnt   = q.swap_cnt + 16'd1;
               if (mem_err) begin
                  d.res.trap_valid = 1'b1;
                  d.res.trap       = ILUS_TRAP_ACCESS;
                  d.last_trap      = ILUS_TRAP_ACCESS;
               end
            end
         end
         default: d.st = ILUS_IDLE;
      endcase
      // Wishbone slave: one wait state, unmapped reads return zero
      if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
         d.wb_ack = 1'b1;
         d.wb_dat = 32'h0000_0000;
         case (wb_adr_i)
            `ILUS_ADR_CFG: begin
               d.wb_dat = {16'h0000, q.cfg};
               if (wb_we_i && wb_sel_i[0]) begin
                  d.cfg[7:0] = wb_dat_i[7:0];
               end
               if (wb_we_i && wb_sel_i[1]) begin
                  d.cfg[15:8] = wb_dat_i[15:8];
               end
            end
            `ILUS_ADR_STATUS: d.wb_dat = {28'h000_0000, q.last_trap, q.st != ILUS_IDLE};
            `ILUS_ADR_COUNT:  d.wb_dat = {16'h0000, q.swap_cnt};
            default:          d.wb_dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         q       <= '0;
         q.st    <= ILUS_IDLE;
         q.cfg   <= `ILUS_CFG_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Busy gates interrupts in the pipeline between read and write halves
   assign atomic_busy = q.st != ILUS_IDLE;
   assign iss_ready   = q.st == ILUS_IDLE;
   assign res         = q.res;
   assign mem.req     = q.st != ILUS_IDLE;
   assign mem.we      = q.st == ILUS_WR;
   assign mem.lock    = q.st != ILUS_IDLE;
   assign mem.addr    = q.addr;
   assign mem.asi     = q.asi;
   assign mem.wdata   = q.wdata;
   assign wb_ack_o    = q.wb_ack;
   assign wb_dat_o    = q.wb_dat;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_ok_n);

   upper_result_a: assert property (iss_fire && is_upper && !is_nop
      |=> res.valid && res.wr_en && res.data == {$past(iss_instr[21:0]), 10'h000})
      else $error("upper-immediate result wrong");
   upper_keeps_cc_a: assert property (iss_fire && is_upper |=> !res.icc_wr)
      else $error("upper-immediate touched flags");
   nop_quiet_a: assert property (iss_fire && is_nop
      |=> res.valid && !res.wr_en && !res.icc_wr && !res.trap_valid && res.pc_adv)
      else $error("no-operation changed state");
   cc_select_a: assert property (iss_fire && is_logic
      |=> res.icc_wr == $past(iss_instr[23]) && res.wr_en)
      else $error("flag update on wrong form");
   flag_value_a: assert property (res.icc_wr
      |-> res.icc == {res.data[31], res.data == 32'd0, 2'b00})
      else $error("flag values wrong");
   logic_no_trap_a: assert property (iss_fire && (is_logic || is_upper)
      |=> !res.trap_valid)
      else $error("logical op trapped");
   swap_alt_imm_a: assert property (iss_fire && is_swap_alt && f_imm
      |=> res.trap_valid && res.trap == ILUS_TRAP_ILLEG ##1 !mem.req)
      else $error("alternate swap with immediate not trapped");
   align_trap_a: assert property (iss_fire && is_swap && eff_addr[1:0] != 2'b00
      |=> res.trap == ILUS_TRAP_ALIGN && !mem.req)
      else $error("misaligned swap reached memory");
   swap_addr_a: assert property (iss_fire && is_swap && eff_addr[1:0] == 2'b00
      |=> mem.req && !mem.we && mem.addr == $past(iss_src_a) + $past(opnd_b))
      else $error("swap address wrong");
   atomic_pair_a: assert property (q.st == ILUS_RD && mem_ack && !mem_err
      |=> mem.req && mem.we && mem.lock && atomic_busy)
      else $error("write half not locked after read");
endmodule

// >>> src/ilus_pkg.sv
// Types shared by the integer logic, upper-immediate and swap slice
// Assumes ilus_consts.svh sits on the include path
package ilus_pkg;
   typedef enum logic [1:0] {
      ILUS_IDLE = 2'b00,
      ILUS_RD   = 2'b01,
      ILUS_WR   = 2'b10
   } ilus_st_e;
   typedef enum logic [2:0] {
      ILUS_TRAP_NONE   = 3'b000,
      ILUS_TRAP_ILLEG  = 3'b001,
      ILUS_TRAP_PRIV   = 3'b010,
      ILUS_TRAP_ALIGN  = 3'b011,
      ILUS_TRAP_ACCESS = 3'b100
   } ilus_trap_e;
   typedef struct packed {
      logic        valid;
      logic        wr_en;
      logic [4:0]  rd;
      logic [31:0] data;
      logic        icc_wr;
      logic [3:0]  icc;
      logic        trap_valid;
      ilus_trap_e  trap;
      logic        pc_adv;
   } ilus_res_s;
   typedef struct packed {
      logic        req;
      logic        we;
      logic        lock;
      logic [31:0] addr;
      logic [7:0]  asi;
      logic [31:0] wdata;
   } ilus_mem_s;
endpackage

// >>> verif/ilus_mem_model.sv
// Memory model answering the swap port of the execution slice
// Assumes one requester on clk_sys; the bench sets latency and faults
module ilus_mem_model (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire ilus_pkg::ilus_mem_s mem,
   input  wire logic [3:0]          lat,
   input  wire logic                err_rd,
   input  wire logic                err_wr,
   output logic                     mem_ack,
   output logic                     mem_err,
   output logic [31:0]              mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import ilus_pkg::*;
   logic [31:0] ram [16];
   logic [31:0] adr_seen;
   logic [7:0]  asi_seen;
   logic        lock_seen;
   logic [3:0]  wait_q;
   int          n_acc = 0;
   // ----------------------------------------
   // Single port: atomics land in a serial order
   // ----------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         wait_q  <= 4'h0;
      end else if (mem_ack) begin
         mem_ack   <= 1'b0;
         mem_err   <= 1'b0;
         wait_q    <= 4'h0;
         // Stale read data is scrambled so a late sample shows up
         mem_rdata <= ~mem_rdata;
      end else if (mem.req && wait_q >= lat) begin
         mem_ack  <= 1'b1;
         mem_err  <= mem.we ? err_wr : err_rd;
         adr_seen <= mem.addr;
         asi_seen <= mem.asi;
         lock_seen <= mem.lock;
         n_acc    <= n_acc + 1;
         if (!mem.we) mem_rdata <= ram[mem.addr[5:2]];
         // Faulted write half leaves the word as it was
         if (mem.we && !err_wr) ram[mem.addr[5:2]] <= mem.wdata;
      end else if (mem.req) begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

// >>> verif/tb_ilus_exec.sv
// Self-checking bench for the logic, upper-immediate and swap slice
// Assumes ilus_exec and ilus_mem_model; config reached over Wishbone
module tb_ilus_exec;
   timeunit 1ns;
   timeprecision 1ns;
   import ilus_pkg::*;
   logic        clk_sys = 1'b0, rst_n = 1'b0, iss_valid = 1'b0, sup = 1'b1;
   logic        err_rd = 1'b0, err_wr = 1'b0, cyc = 1'b0, we = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0, lat = 4'h0;
   logic [31:0] ins = 32'h0000_0000, sa = 32'h0000_0000, sb = 32'h0000_0000;
   logic [31:0] rv = 32'h0000_0000, wdw = 32'h0000_0000, q;
   logic        iss_ready, atomic_busy, mem_ack, mem_err, wb_ack_o;
   logic [31:0] mem_rdata, wb_dat_o;
   ilus_res_s   res, r;
   ilus_mem_s   mem;
   int          n_fail = 0, n_compared = 0;
   ilus_exec ilus_exec_i (
      .clk_sys, .rst_n, .iss_valid, .iss_ready, .iss_instr(ins), .iss_src_a(sa),
      .iss_src_b(sb), .iss_rd_val(rv), .processor_state_word_s(sup), .res,
      .atomic_busy, .mem, .mem_ack, .mem_err, .mem_rdata, .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdw), .wb_dat_o, .wb_ack_o);
   ilus_mem_model ilus_mem_model_i (
      .clk_sys, .rst_n, .mem, .lat, .err_rd, .err_wr, .mem_ack, .mem_err, .mem_rdata);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [31:0] f3(input logic [1:0] op, input logic [5:0] o3,
                                      input logic i, input logic [12:0] lo);
      return {op, 5'h07, o3, 5'h01, i, lo};
   endfunction
   task automatic issue(input logic [31:0] i, a, b, v);
      int k;
      @(posedge clk_sys);
      iss_valid <= 1'b1;
      ins       <= i;
      sa        <= a;
      sb        <= b;
      rv        <= v;
      @(negedge clk_sys);
      for (k = 0; k < 300 && iss_ready !== 1'b1; k++) @(negedge clk_sys);
      @(posedge clk_sys);
      iss_valid <= 1'b0;
      for (k = 0; k < 300 && res.valid !== 1'b1; k++) @(negedge clk_sys);
      r = res;
      chk(res.valid, 1'b1);
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      @(posedge clk_sys);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      wdw <= d;
      // Only wb_ack_o or the watchdog ends this wait
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
   endtask
   task automatic swap(input logic [31:0] i, a, b, input logic [2:0] tr,
                       input logic [7:0] asi, input int nacc);
      logic [31:0] ea;
      int          n0;
      ea = a + (i[13] ? {{19{i[12]}}, i[12:0]} : b);
      n0 = ilus_mem_model_i.n_acc;
      ilus_mem_model_i.ram[ea[5:2]] = 32'h5A00_0000 ^ ea;
      issue(i, a, b, 32'hC0DE_0000 ^ ea);
      chk(r.trap_valid, tr != 3'h0);
      chk(r.trap, tr);
      chk(ilus_mem_model_i.n_acc - n0, nacc);
      chk(r.wr_en, nacc == 2);
      chk(r.pc_adv, tr == 3'h0);
      if (nacc == 2) begin
         chk(r.data, 32'h5A00_0000 ^ ea);
         chk(ilus_mem_model_i.adr_seen, ea);
         chk(ilus_mem_model_i.asi_seen, asi);
         chk(ilus_mem_model_i.lock_seen, 1'b1);
      end
      if (tr == 3'h0) chk(ilus_mem_model_i.ram[ea[5:2]], 32'hC0DE_0000 ^ ea);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_logic();
      logic [3:0]  code [6] = '{4'h1, 4'h5, 4'h2, 4'h6, 4'h3, 4'h7};
      logic [31:0] a, b2, y;
      logic [3:0]  cd;
      logic        cc, im;
      a = 32'h8421_0FF0;
      for (int m = 0; m < 24; m++) begin
         cd = code[m % 6];
         cc = ((m / 6) % 2) == 1;
         im = m >= 12;
         b2 = im ? 32'hFFFF_FF0C : 32'h0F0F_F00F;
         if (cd[2]) b2 = ~b2;
         y = (cd[1:0] == 2'h1) ? a & b2 : (cd[1:0] == 2'h2) ? a | b2 : a ^ b2;
         issue(f3(2'h2, {1'b0, cc, cd}, im, im ? 13'h1F0C : 13'h0002), a,
               32'h0F0F_F00F, 32'h0000_0000);
         chk(r.data, y);
         chk(r.icc_wr, cc);
         if (cc) chk(r.icc, {y[31], y == 32'h0000_0000, 2'h0});
         chk({r.wr_en, r.rd, r.trap_valid, r.pc_adv}, {1'b1, 5'h07, 2'h1});
      end
      issue(f3(2'h2, 6'h13, 1'b0, 13'h0002), a, a, 32'h0000_0000);
      chk(r.data, 32'h0000_0000);
      chk(r.icc, 4'h4);
   endtask
   task automatic sc_upper();
      issue({2'h0, 5'h05, 3'h4, 22'h2A_BCDE}, a_ones(), a_ones(), 32'h0000_0000);
      chk(r.data, {22'h2A_BCDE, 10'h000});
      chk({r.wr_en, r.rd, r.icc_wr, r.trap_valid}, {1'b1, 5'h05, 2'h0});
      issue(32'h0100_0000, a_ones(), a_ones(), 32'h0000_0000);
      chk({r.wr_en, r.icc_wr, r.trap_valid, r.pc_adv}, 4'h1);
      // Add lies outside this slice, so it must come back as illegal
      issue(f3(2'h2, 6'h00, 1'b0, 13'h0002), a_ones(), a_ones(), 32'h0000_0000);
      chk({r.trap_valid, r.trap, r.wr_en, r.pc_adv}, {1'b1, 3'h1, 2'h0});
   endtask
   function automatic logic [31:0] a_ones();
      return 32'hFFFF_FFFF;
   endfunction
   task automatic sc_swap();
      wb(1'b0, 4'h0, 4'hF, 32'h0000_0000);
      chk(q, 32'h0000_0201);
      wb(1'b1, 4'h0, 4'h1, 32'hFFFF_0705);
      wb(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF);
      wb(1'b0, 4'h0, 4'hF, 32'h0000_0000);
      chk(q, 32'h0000_0205);
      wb(1'b0, 4'hC, 4'hF, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      swap(f3(2'h3, 6'h0F, 1'b0, 13'h0002), 32'h20, 32'h8, 3'h0, 8'h02, 2);
      @(posedge clk_sys);
      sup <= 1'b0;
      lat <= 4'h3;
      swap(f3(2'h3, 6'h0F, 1'b1, 13'h1FFC), 32'h30, 32'h8, 3'h0, 8'h05, 2);
      swap(f3(2'h3, 6'h1F, 1'b1, 13'h0004), 32'h10, 32'h8, 3'h1, 8'h00, 0);
      swap(f3(2'h3, 6'h1F, 1'b0, 13'h0162), 32'h10, 32'h4, 3'h2, 8'h00, 0);
      @(posedge clk_sys);
      sup <= 1'b1;
      swap(f3(2'h3, 6'h1F, 1'b0, 13'h0162), 32'h10, 32'h4, 3'h0, 8'h0B, 2);
      swap(f3(2'h3, 6'h0F, 1'b0, 13'h0002), 32'h10, 32'h2, 3'h3, 8'h00, 0);
      @(posedge clk_sys);
      err_wr <= 1'b1;
      swap(f3(2'h3, 6'h0F, 1'b0, 13'h0002), 32'h18, 32'h0, 3'h4, 8'h02, 2);
      @(posedge clk_sys);
      err_wr <= 1'b0;
      err_rd <= 1'b1;
      swap(f3(2'h3, 6'h0F, 1'b0, 13'h0002), 32'h1C, 32'h0, 3'h4, 8'h02, 1);
      @(posedge clk_sys);
      err_rd <= 1'b0;
      wb(1'b0, 4'h8, 4'hF, 32'h0000_0000);
      chk(q, 32'h0000_0004);
      wb(1'b0, 4'h4, 4'hF, 32'h0000_0000);
      chk(q, 32'h0000_0008);
      wb(1'b1, 4'h0, 4'h2, 32'h0000_3300);
      wb(1'b0, 4'h0, 4'hF, 32'h0000_0000);
      chk(q, 32'h0000_3305);
   endtask
   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sc_logic();
      sc_upper();
      sc_swap();
      report_and_stop();
   end
endmodule
